// >>> usb_ep_ctrl_pkg.sv
// constants for the low-speed endpoint handshake control
package usb_ep_ctrl_pkg;
	// register addresses on the special-function register port
	localparam logic [7:0] EP0_TX_CTRL_ADDR  = 8'hEA;
	localparam logic [7:0] EP12_TX_CTRL_ADDR = 8'hEB;
	localparam logic [7:0] EP_EN_STALL_ADDR  = 8'hEC;
	localparam logic [7:0] EP0_RX_STAT_ADDR  = 8'hED;
	// reset values
	localparam logic [7:0] CTRL_RESET_VAL    = 8'h00;
	localparam logic [3:0] COUNT_RESET_VAL   = 4'h0;
	// endpoint0 transmit control fields
	localparam int EP0_SEQ_BIT        = 7;
	localparam int EP0_STALL_BIT      = 6;
	localparam int EP0_TXEN_BIT       = 5;
	localparam int EP0_RXEN_BIT       = 4;
	// endpoint1/2 transmit control fields
	localparam int SH_SEQ_BIT         = 7;
	localparam int SH_SEL_BIT         = 6;
	localparam int SH_TXEN_BIT        = 5;
	localparam int WAKEUP_BIT         = 4;
	// enable and stall control fields
	localparam int AUTO_AUTO_STATUS_OUT_BIT      = 4;
	localparam int EP2_EN_BIT         = 3;
	localparam int EP1_EN_BIT         = 2;
	localparam int EP2_STALL_BIT      = 1;
	localparam int EP1_STALL_BIT      = 0;
	// endpoint0 status fields
	localparam int RX_SEQ_BIT         = 7;
	localparam int TOK_SETUP_BIT      = 6;
	localparam int TOK_IN_BIT         = 5;
	localparam int TOK_OUT_BIT        = 4;
	localparam int COUNT_MSB          = 3;
	// token packet identifiers
	localparam logic [3:0] PID_OUT    = 4'h1;
	localparam logic [3:0] PID_IN     = 4'h9;
	localparam logic [3:0] PID_SETUP  = 4'hD;
	// endpoint numbers
	localparam logic [1:0] EP_ZERO    = 2'h0;
	localparam logic [1:0] EP_ONE     = 2'h1;
	localparam logic [1:0] EP_TWO     = 2'h2;
	// answer kinds handed to the packet engine
	typedef enum logic [1:0] {ANS_DATA, ANS_NAK, ANS_STALL, ANS_ACK} ans_kind_t;
	// answer word: kind, data1, count, endpoint
	localparam int ANS_W              = 9;
endpackage : usb_ep_ctrl_pkg

// >>> usb_ans_buf.sv
// two-entry answer buffer with registered outputs
`timescale 1ns/100ps
module usb_ans_buf #(
	parameter int W = 9
) (
	input  wire logic         clk,        // system clock
	input  wire logic         rst,        // async reset, high
	input  wire logic         in_valid,   // word offered
	output logic              in_ready,   // room for a word
	input  wire logic [W-1:0] in_data,    // offered word
	output logic              out_valid,  // head word present
	input  wire logic         out_ready,  // drain side takes head
	output logic [W-1:0]      out_data    // head word
);
	logic [W-1:0] head_ff, nxt_head;
	logic [W-1:0] tail_ff, nxt_tail;
	logic [1:0]   cnt_ff,  nxt_cnt;
	logic         push;
	logic         pop;
	logic         val_ff,  nxt_val;
	logic         rdy_ff,  nxt_rdy;

	// next head, tail and fill level
	always_comb begin
		push     = in_valid && (cnt_ff != 2'h2);
		pop      = (cnt_ff != 2'h0) && out_ready;
		nxt_head = head_ff;
		nxt_tail = tail_ff;
		nxt_cnt  = cnt_ff;
		case (cnt_ff)
			2'h0: begin
				if (push) begin
					nxt_head = in_data;
					nxt_cnt  = 2'h1;
				end
			end
			2'h1: begin
				if (push && pop) begin
					nxt_head = in_data;
				end else if (pop) begin
					nxt_cnt = 2'h0;
				end else if (push) begin
					nxt_tail = in_data;
					nxt_cnt  = 2'h2;
				end
			end
			default: begin
				if (pop) begin
					nxt_head = tail_ff;
					nxt_cnt  = 2'h1;
				end
			end
		endcase
		// flags from the next level so both ports leave flip-flops
		nxt_val = (nxt_cnt != 2'h0);
		nxt_rdy = (nxt_cnt != 2'h2);
	end

	// storage registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			head_ff <= '0;
			tail_ff <= '0;
			cnt_ff  <= 2'h0;
			val_ff  <= 1'b0;
			rdy_ff  <= 1'b1;
		end else begin
			head_ff <= nxt_head;
			tail_ff <= nxt_tail;
			cnt_ff  <= nxt_cnt;
			val_ff  <= nxt_val;
			rdy_ff  <= nxt_rdy;
		end
	end

	assign in_ready  = rdy_ff;
	assign out_valid = val_ff;
	assign out_data  = head_ff;
endmodule : usb_ans_buf

// >>> usb_ep_ctrl.sv
// endpoint handshake control for a low-speed usb function
`timescale 1ns/100ps
module usb_ep_ctrl (
	input  wire logic       SYS_CLK,        // 100 MHz clock
	input  wire logic       RST,            // async reset, high
	input  wire logic [7:0] SFR_ADDR,       // register address
	input  wire logic       SFR_WR,         // write strobe
	input  wire logic       SFR_RD,         // read strobe
	input  wire logic [7:0] SFR_WDATA,      // write data
	output logic      [7:0] SFR_RDATA,      // read data, registered
	input  wire logic       TOK_VALID,      // token from packet engine
	output logic            TOK_READY,      // token taken
	input  wire logic [3:0] TOK_PID,        // token pid
	input  wire logic [1:0] TOK_EP,         // token endpoint
	input  wire logic       RXD_VALID,      // endpoint0 data packet received
	input  wire logic [3:0] RXD_COUNT,      // bytes in that packet
	input  wire logic       HOST_ACK,       // host acked our data packet
	input  wire logic       BUS_RESUME,     // bus activity while suspended
	input  wire logic       EP0_TX_DONE_CLR,// firmware clears ep0 tx done
	input  wire logic       EP0_RX_DONE_CLR,// firmware clears ep0 rx done
	input  wire logic       SH_TX_DONE_CLR, // firmware clears shared tx done
	input  wire logic       RESUME_CLR,     // firmware clears resume flag
	output logic            EP0_TX_DONE,    // ep0 transmit done flag
	output logic            EP0_RX_DONE,    // ep0 receive done flag
	output logic            SH_TX_DONE,     // shared transmit done flag
	output logic            RESUME_FLAG,    // resume detected flag
	output logic            FORCE_K,        // drive K state on lines
	output logic            ANS_VALID,      // answer offered
	input  wire logic       ANS_READY,      // engine takes answer
	output logic      [1:0] ANS_KIND,       // data, nak, stall or ack
	output logic            ANS_DATA1,      // data pid is DATA1
	output logic      [3:0] ANS_COUNT,      // data bytes to send
	output logic      [1:0] ANS_EP          // endpoint answered
);
	// control and status registers
	logic [7:0] ep0_ctrl_ff,  nxt_ep0_ctrl;
	logic [7:0] sh_ctrl_ff,   nxt_sh_ctrl;
	logic [4:0] en_ctrl_ff,   nxt_en_ctrl;
	logic [7:0] rx_stat_ff,   nxt_rx_stat;
	logic [7:0] rdata_ff,     nxt_rdata;
	logic       ep0_txd_ff,   nxt_ep0_txd;
	logic       ep0_rxd_ff,   nxt_ep0_rxd;
	logic       sh_txd_ff,    nxt_sh_txd;
	logic       resume_ff,    nxt_resume;
	logic       wake_ff,      nxt_wake;
	logic [1:0] sent_ep_ff,   nxt_sent_ep;
	logic       sent_ff,      nxt_sent;
	// answer decision
	usb_ep_ctrl_pkg::ans_kind_t ans_kind;
	logic       ans_seq;
	logic [3:0] ans_cnt;
	logic       ans_push;
	logic       tok_take;
	logic       buf_ready;
	logic [usb_ep_ctrl_pkg::ANS_W-1:0] buf_out;
	logic       is_in;
	logic       is_out;
	logic       is_setup;
	logic       wr0, wr1, wr2, wr3;

	assign is_in    = (TOK_PID == usb_ep_ctrl_pkg::PID_IN);
	assign is_out   = (TOK_PID == usb_ep_ctrl_pkg::PID_OUT);
	assign is_setup = (TOK_PID == usb_ep_ctrl_pkg::PID_SETUP);
	assign tok_take = TOK_VALID && buf_ready;

	// handshake choice for the offered token
	always_comb begin
		ans_kind = usb_ep_ctrl_pkg::ANS_NAK;
		ans_seq  = 1'b0;
		ans_cnt  = usb_ep_ctrl_pkg::COUNT_RESET_VAL;
		ans_push = tok_take && (TOK_EP != 2'h3) && (is_in || is_out || is_setup);
		if (TOK_EP == usb_ep_ctrl_pkg::EP_ZERO) begin
			if (is_setup) begin
				ans_kind = usb_ep_ctrl_pkg::ANS_ACK;
			end else if (ep0_ctrl_ff[usb_ep_ctrl_pkg::EP0_STALL_BIT]) begin
				ans_kind = usb_ep_ctrl_pkg::ANS_STALL;
			end else if (is_in) begin
				if (!ep0_ctrl_ff[usb_ep_ctrl_pkg::EP0_TXEN_BIT] || ep0_txd_ff) begin
					ans_kind = usb_ep_ctrl_pkg::ANS_NAK;
				end else begin
					ans_kind = usb_ep_ctrl_pkg::ANS_DATA;
					ans_seq  = ep0_ctrl_ff[usb_ep_ctrl_pkg::EP0_SEQ_BIT];
					ans_cnt  = ep0_ctrl_ff[usb_ep_ctrl_pkg::COUNT_MSB:0];
				end
			end else if (en_ctrl_ff[usb_ep_ctrl_pkg::AUTO_AUTO_STATUS_OUT_BIT]) begin
				ans_kind = usb_ep_ctrl_pkg::ANS_ACK;
			end else if (!ep0_ctrl_ff[usb_ep_ctrl_pkg::EP0_RXEN_BIT] || ep0_rxd_ff) begin
				ans_kind = usb_ep_ctrl_pkg::ANS_NAK;
			end else begin
				ans_kind = usb_ep_ctrl_pkg::ANS_ACK;
			end
		end else if ((TOK_EP == usb_ep_ctrl_pkg::EP_ONE &&
				en_ctrl_ff[usb_ep_ctrl_pkg::EP1_STALL_BIT]) ||
				(TOK_EP == usb_ep_ctrl_pkg::EP_TWO &&
				en_ctrl_ff[usb_ep_ctrl_pkg::EP2_STALL_BIT])) begin
			ans_kind = usb_ep_ctrl_pkg::ANS_STALL;
		end else if (!is_in) begin
			ans_kind = usb_ep_ctrl_pkg::ANS_NAK;
		end else if (!sh_ctrl_ff[usb_ep_ctrl_pkg::SH_TXEN_BIT] || sh_txd_ff) begin
			ans_kind = usb_ep_ctrl_pkg::ANS_NAK;
		end else if (sh_ctrl_ff[usb_ep_ctrl_pkg::SH_SEL_BIT] != TOK_EP[1]) begin
			ans_kind = usb_ep_ctrl_pkg::ANS_NAK;
		end else if ((TOK_EP == usb_ep_ctrl_pkg::EP_ONE &&
				!en_ctrl_ff[usb_ep_ctrl_pkg::EP1_EN_BIT]) ||
				(TOK_EP == usb_ep_ctrl_pkg::EP_TWO &&
				!en_ctrl_ff[usb_ep_ctrl_pkg::EP2_EN_BIT])) begin
			ans_kind = usb_ep_ctrl_pkg::ANS_NAK;
		end else begin
			ans_kind = usb_ep_ctrl_pkg::ANS_DATA;
			ans_seq  = sh_ctrl_ff[usb_ep_ctrl_pkg::SH_SEQ_BIT];
			ans_cnt  = sh_ctrl_ff[usb_ep_ctrl_pkg::COUNT_MSB:0];
		end
	end

	// write strobe decode, one register per address
	always_comb begin
		wr0 = 1'b0;
		wr1 = 1'b0;
		wr2 = 1'b0;
		wr3 = 1'b0;
		if (SFR_WR) begin
			if (SFR_ADDR == usb_ep_ctrl_pkg::EP0_TX_CTRL_ADDR) begin
				wr0 = 1'b1;
			end else if (SFR_ADDR == usb_ep_ctrl_pkg::EP12_TX_CTRL_ADDR) begin
				wr1 = 1'b1;
			end else if (SFR_ADDR == usb_ep_ctrl_pkg::EP_EN_STALL_ADDR) begin
				wr2 = 1'b1;
			end else if (SFR_ADDR == usb_ep_ctrl_pkg::EP0_RX_STAT_ADDR) begin
				wr3 = 1'b1;
			end
		end
	end

	// next control values; a setup token clears the stall over a write
	always_comb begin
		nxt_ep0_ctrl = wr0 ? SFR_WDATA : ep0_ctrl_ff;
		nxt_sh_ctrl  = wr1 ? SFR_WDATA : sh_ctrl_ff;
		nxt_en_ctrl  = wr2 ? SFR_WDATA[4:0] : en_ctrl_ff;
		if (tok_take && is_setup && TOK_EP == usb_ep_ctrl_pkg::EP_ZERO) begin
			nxt_ep0_ctrl[usb_ep_ctrl_pkg::EP0_STALL_BIT] = 1'b0;
		end
		nxt_wake     = nxt_sh_ctrl[usb_ep_ctrl_pkg::WAKEUP_BIT];
	end

	// control registers and the wakeup drive copy
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ep0_ctrl_ff <= usb_ep_ctrl_pkg::CTRL_RESET_VAL;
			sh_ctrl_ff  <= usb_ep_ctrl_pkg::CTRL_RESET_VAL;
			en_ctrl_ff  <= 5'h00;
			wake_ff     <= 1'b0;
		end else begin
			ep0_ctrl_ff <= nxt_ep0_ctrl;
			sh_ctrl_ff  <= nxt_sh_ctrl;
			en_ctrl_ff  <= nxt_en_ctrl;
			wake_ff     <= nxt_wake;
		end
	end

	// next endpoint0 status: sequence bit, last token kind, byte count
	always_comb begin
		nxt_rx_stat = rx_stat_ff;
		if (wr3) begin
			nxt_rx_stat[usb_ep_ctrl_pkg::RX_SEQ_BIT] = SFR_WDATA[usb_ep_ctrl_pkg::RX_SEQ_BIT];
		end
		if (tok_take && TOK_EP == usb_ep_ctrl_pkg::EP_ZERO &&
				(is_in || is_out || is_setup)) begin
			nxt_rx_stat[usb_ep_ctrl_pkg::TOK_SETUP_BIT] = is_setup;
			nxt_rx_stat[usb_ep_ctrl_pkg::TOK_IN_BIT]    = is_in;
			nxt_rx_stat[usb_ep_ctrl_pkg::TOK_OUT_BIT]   = is_out;
		end
		if (RXD_VALID) begin
			nxt_rx_stat[usb_ep_ctrl_pkg::COUNT_MSB:0] = RXD_COUNT;
		end
	end

	// endpoint0 status register
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rx_stat_ff <= usb_ep_ctrl_pkg::CTRL_RESET_VAL;
		end else begin
			rx_stat_ff <= nxt_rx_stat;
		end
	end

	// next tracker: endpoint of the last queued data packet
	always_comb begin
		nxt_sent    = sent_ff;
		nxt_sent_ep = sent_ep_ff;
		if (ans_push && ans_kind == usb_ep_ctrl_pkg::ANS_DATA) begin
			nxt_sent    = 1'b1;
			nxt_sent_ep = TOK_EP;
		end else if (HOST_ACK) begin
			nxt_sent    = 1'b0;
		end
	end

	// data packet tracker
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sent_ff    <= 1'b0;
			sent_ep_ff <= 2'h0;
		end else begin
			sent_ff    <= nxt_sent;
			sent_ep_ff <= nxt_sent_ep;
		end
	end

	// next done and resume flags: hardware set wins over firmware clear
	always_comb begin
		nxt_ep0_txd = (ep0_txd_ff && !EP0_TX_DONE_CLR) ||
			(HOST_ACK && sent_ff && sent_ep_ff == usb_ep_ctrl_pkg::EP_ZERO);
		nxt_sh_txd  = (sh_txd_ff && !SH_TX_DONE_CLR) ||
			(HOST_ACK && sent_ff && sent_ep_ff != usb_ep_ctrl_pkg::EP_ZERO);
		nxt_ep0_rxd = (ep0_rxd_ff && !EP0_RX_DONE_CLR) ||
			(RXD_VALID && !en_ctrl_ff[usb_ep_ctrl_pkg::AUTO_AUTO_STATUS_OUT_BIT]);
		nxt_resume  = (resume_ff && !RESUME_CLR) || BUS_RESUME;
	end

	// done and resume flags
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			ep0_txd_ff <= 1'b0;
			ep0_rxd_ff <= 1'b0;
			sh_txd_ff  <= 1'b0;
			resume_ff  <= 1'b0;
		end else begin
			ep0_txd_ff <= nxt_ep0_txd;
			ep0_rxd_ff <= nxt_ep0_rxd;
			sh_txd_ff  <= nxt_sh_txd;
			resume_ff  <= nxt_resume;
		end
	end

	// next read data, unmapped reads and idle cycles give zero
	always_comb begin
		nxt_rdata = 8'h00;
		if (SFR_RD) begin
			if (SFR_ADDR == usb_ep_ctrl_pkg::EP0_TX_CTRL_ADDR) begin
				nxt_rdata = ep0_ctrl_ff;
			end else if (SFR_ADDR == usb_ep_ctrl_pkg::EP12_TX_CTRL_ADDR) begin
				nxt_rdata = sh_ctrl_ff;
			end else if (SFR_ADDR == usb_ep_ctrl_pkg::EP_EN_STALL_ADDR) begin
				nxt_rdata = {3'h0, en_ctrl_ff};
			end else if (SFR_ADDR == usb_ep_ctrl_pkg::EP0_RX_STAT_ADDR) begin
				nxt_rdata = rx_stat_ff;
			end
		end
	end

	// registered read data
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// answers queue here so an engine stall loses none
	usb_ans_buf #(
		.W (usb_ep_ctrl_pkg::ANS_W)
	) u_ans_buf (
		.clk       (SYS_CLK),
		.rst       (RST),
		.in_valid  (ans_push),
		.in_ready  (buf_ready),
		.in_data   ({ans_kind, ans_seq, ans_cnt, TOK_EP}),
		.out_valid (ANS_VALID),
		.out_ready (ANS_READY),
		.out_data  (buf_out)
	);

	// outputs
	assign TOK_READY   = buf_ready;
	assign SFR_RDATA   = rdata_ff;
	assign EP0_TX_DONE = ep0_txd_ff;
	assign EP0_RX_DONE = ep0_rxd_ff;
	assign SH_TX_DONE  = sh_txd_ff;
	assign RESUME_FLAG = resume_ff;
	assign FORCE_K     = wake_ff;
	assign ANS_KIND    = buf_out[8:7];
	assign ANS_DATA1   = buf_out[6];
	assign ANS_COUNT   = buf_out[5:2];
	assign ANS_EP      = buf_out[1:0];
endmodule : usb_ep_ctrl

// >>> usb_ep_ctrl_props.sv
// port checker for the endpoint handshake control
`timescale 1ns/100ps
module usb_ep_ctrl_props (
	input wire logic       SYS_CLK,     // clock
	input wire logic       RST,         // reset
	input wire logic [7:0] SFR_ADDR,    // address
	input wire logic       SFR_WR,      // write
	input wire logic       SFR_RD,      // read
	input wire logic [7:0] SFR_WDATA,   // write data
	input wire logic [7:0] SFR_RDATA,   // read data
	input wire logic       TOK_VALID,   // token offered
	input wire logic       TOK_READY,   // token taken
	input wire logic [3:0] TOK_PID,     // token pid
	input wire logic [1:0] TOK_EP,      // token endpoint
	input wire logic       HOST_ACK,    // host ack
	input wire logic       BUS_RESUME,  // bus resume
	input wire logic       EP0_TX_DONE, // ep0 done
	input wire logic       SH_TX_DONE,  // shared done
	input wire logic       RESUME_FLAG, // resume flag
	input wire logic       FORCE_K,     // drive K
	input wire logic       ANS_VALID,   // answer offered
	input wire logic       ANS_READY,   // answer taken
	input wire logic [1:0] ANS_KIND     // answer kind
);
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RST);
	logic take, wr_eb, rd_ec;
	// token into an empty buffer, register strobes
	assign take = TOK_VALID && TOK_READY && !ANS_VALID;
	assign wr_eb = SFR_WR && SFR_ADDR == 8'hEB;
	assign rd_ec = SFR_RD && SFR_ADDR == 8'hEC;
	a_wake_copy: assert property ($past(wr_eb, 2) && !$past(wr_eb)
		|-> FORCE_K == $past(SFR_WDATA[4], 2)) else $error("wakeup drive wrong");
	a_resume_src: assert property ($rose(RESUME_FLAG) |-> $past(BUS_RESUME))
		else $error("resume flag without bus resume");
	a_txdone_src: assert property ($rose(EP0_TX_DONE) |-> $past(HOST_ACK))
		else $error("ep0 done without host ack");
	a_ep0_in_nak: assert property (
		take && TOK_PID == 4'h9 && TOK_EP == 2'h0 && EP0_TX_DONE |=> ANS_KIND inside {2'h1, 2'h2})
		else $error("ep0 IN not refused");
	a_sh_in_nak: assert property (
		take && TOK_PID == 4'h9 && TOK_EP inside {2'h1, 2'h2} && SH_TX_DONE
		|=> ANS_KIND inside {2'h1, 2'h2}) else $error("shared IN not refused");
	a_setup_ack: assert property (
		take && TOK_PID == 4'hD && TOK_EP == 2'h0 |=> ANS_VALID && ANS_KIND == 2'h3)
		else $error("setup not acked");
	a_ans_hold: assert property (ANS_VALID && !ANS_READY |=> ANS_VALID && $stable(ANS_KIND))
		else $error("answer dropped");
	a_full_refuse: assert property (!TOK_READY |-> ANS_VALID) else $error("refused while empty");
	a_rsv_zero: assert property ($past(rd_ec) |-> SFR_RDATA[7:5] == 3'h0)
		else $error("reserved bits read back");
	a_rdata_idle: assert property (!$past(SFR_RD) |-> SFR_RDATA == 8'h00)
		else $error("read data outside read");
	c_data: cover property (ANS_VALID && ANS_READY && ANS_KIND == 2'h0);
	c_full: cover property (!TOK_READY);
	c_wake: cover property ($rose(FORCE_K));
endmodule : usb_ep_ctrl_props
bind usb_ep_ctrl usb_ep_ctrl_props chk (.SYS_CLK, .RST, .SFR_ADDR, .SFR_WR, .SFR_RD, .SFR_WDATA,
	.SFR_RDATA, .TOK_VALID, .TOK_READY, .TOK_PID, .TOK_EP, .HOST_ACK, .BUS_RESUME, .EP0_TX_DONE,
	.SH_TX_DONE, .RESUME_FLAG, .FORCE_K, .ANS_VALID, .ANS_READY, .ANS_KIND);

// >>> usb_host_model.sv
// host packet engine model: tokens out, answers in, acks data
`timescale 1ns/100ps
module usb_host_model (
	input  wire logic       clk,       // clock
	output logic            tok_valid, // token offered
	input  wire logic       tok_ready, // token taken
	output logic      [3:0] tok_pid,   // token pid
	output logic      [1:0] tok_ep,    // token endpoint
	input  wire logic       ans_valid, // answer offered
	output logic            ans_ready, // answer taken
	input  wire logic [8:0] ans,       // kind, data1, count, ep
	output logic            host_ack   // data acked
);
	initial begin
		tok_valid = 1'b0;
		tok_pid = 4'h0;
		tok_ep = 2'h0;
		ans_ready = 1'b0;
		host_ack = 1'b0;
	end
	// hold token until taken, then scramble released lines
	task automatic send(input logic [3:0] pid, input logic [1:0] ep);
		@(posedge clk);
		#1;
		tok_valid = 1'b1;
		tok_pid = pid;
		tok_ep = ep;
		do @(posedge clk); while (tok_ready !== 1'b1);
		#1;
		tok_valid = 1'b0;
		tok_pid = ~pid;
		tok_ep = ~ep;
	endtask : send
	// stall a while, take answer, ack a data packet
	task automatic take(input int slow, output logic [8:0] a);
		repeat (slow) @(posedge clk);
		#1;
		ans_ready = 1'b1;
		do @(posedge clk); while (ans_valid !== 1'b1);
		a = ans;
		#1;
		ans_ready = 1'b0;
		if (a[8:7] === 2'h0) begin
			host_ack = 1'b1;
			@(posedge clk);
			#1;
			host_ack = 1'b0;
		end
	endtask : take
endmodule : usb_host_model

// >>> tb.sv
// self-checking bench for the endpoint handshake control
`timescale 1ns/100ps
module tb;
	logic       clk, rst, wr, rd, tv, tr, ha, f0t, f0r, fsh, frs, fk, av, ar, ad1;
	logic [7:0] adr, wd, rdat;
	logic [5:0] pl;
	logic [3:0] pid, rxc, acnt;
	logic [1:0] tep, akind, aep;
	int         err_count, comparisons;
	usb_ep_ctrl dut (.SYS_CLK(clk), .RST(rst), .SFR_ADDR(adr), .SFR_WR(wr), .SFR_RD(rd),
		.SFR_WDATA(wd), .SFR_RDATA(rdat), .TOK_VALID(tv), .TOK_READY(tr), .TOK_PID(pid),
		.TOK_EP(tep), .RXD_VALID(pl[0]), .RXD_COUNT(rxc), .HOST_ACK(ha), .BUS_RESUME(pl[1]),
		.EP0_TX_DONE_CLR(pl[2]), .EP0_RX_DONE_CLR(pl[3]), .SH_TX_DONE_CLR(pl[4]),
		.RESUME_CLR(pl[5]), .EP0_TX_DONE(f0t), .EP0_RX_DONE(f0r), .SH_TX_DONE(fsh),
		.RESUME_FLAG(frs), .FORCE_K(fk), .ANS_VALID(av), .ANS_READY(ar), .ANS_KIND(akind),
		.ANS_DATA1(ad1), .ANS_COUNT(acnt), .ANS_EP(aep));
	usb_host_model host (.clk(clk), .tok_valid(tv), .tok_ready(tr), .tok_pid(pid), .tok_ep(tep),
		.ans_valid(av), .ans_ready(ar), .ans({akind, ad1, acnt, aep}), .host_ack(ha));
	task automatic chk(input string what, input logic [8:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// register write and read-compare, one strobe cycle each
	task automatic wrr(input logic [7:0] a, d);
		@(posedge clk);
		#1;
		adr = a;
		wd = d;
		wr = 1'b1;
		@(posedge clk);
		#1;
		wr = 1'b0;
	endtask : wrr
	task automatic rdc(input logic [7:0] a, x);
		@(posedge clk);
		#1;
		adr = a;
		rd = 1'b1;
		@(posedge clk);
		#1;
		rd = 1'b0;
		chk("register", {1'b0, rdat}, {1'b0, x});
	endtask : rdc
	// one token and its answer, compared whole
	task automatic ask(input logic [3:0] p, input logic [1:0] e, input logic [8:0] x);
		logic [8:0] a;
		host.send(p, e);
		host.take(0, a);
		chk("answer", a, x);
	endtask : ask
	// pulse: rx data, bus resume, then the four flag clears
	task automatic pulse(input logic [5:0] m);
		@(posedge clk);
		#1;
		pl = m;
		@(posedge clk);
		#1;
		pl = 6'h00;
	endtask : pulse
	task automatic t_regs;
		for (int i = 0; i < 4; i++) rdc(8'hEA + 8'(i), 8'h00);
		wrr(8'hEC, 8'hFF);
		rdc(8'hEC, 8'h1F);
		wrr(8'hEE, 8'hFF);
		rdc(8'hEE, 8'h00);
		wrr(8'hEC, 8'h00);
	endtask : t_regs
	task automatic t_ep0;
		ask(4'h9, 2'h0, 9'h080);
		wrr(8'hEA, 8'hA5);
		ask(4'h9, 2'h0, 9'h054);
		chk("ep0 done", {8'h00, f0t}, 9'h001);
		rdc(8'hEA, 8'hA5);
		ask(4'h9, 2'h0, 9'h080);
		pulse(6'h04);
		wrr(8'hEA, 8'h20);
		ask(4'h9, 2'h0, 9'h000);
		pulse(6'h04);
	endtask : t_ep0
	task automatic t_rx;
		wrr(8'hEA, 8'h50);
		ask(4'h9, 2'h0, 9'h100);
		ask(4'h1, 2'h0, 9'h100);
		ask(4'hD, 2'h0, 9'h180);
		rdc(8'hEA, 8'h10);
		rdc(8'hED, 8'h40);
		ask(4'h1, 2'h0, 9'h180);
		pulse(6'h01);
		chk("ep0 rx done", {8'h00, f0r}, 9'h001);
		ask(4'h1, 2'h0, 9'h080);
		pulse(6'h08);
		wrr(8'hEA, 8'h00);
		ask(4'h1, 2'h0, 9'h080);
		wrr(8'hEC, 8'h10);
		ask(4'h1, 2'h0, 9'h180);
		pulse(6'h01);
		chk("ep0 rx done", {8'h00, f0r}, 9'h000);
		rdc(8'hED, 8'h13);
	endtask : t_rx
	task automatic t_shared;
		wrr(8'hEB, 8'hE7);
		wrr(8'hEC, 8'h0C);
		ask(4'h9, 2'h2, 9'h05E);
		chk("shared done", {8'h00, fsh}, 9'h001);
		ask(4'h9, 2'h1, 9'h081);
		pulse(6'h10);
		wrr(8'hEB, 8'h27);
		ask(4'h9, 2'h2, 9'h082);
		ask(4'h9, 2'h1, 9'h01D);
		pulse(6'h10);
		wrr(8'hEC, 8'h0D);
		ask(4'h9, 2'h1, 9'h101);
		wrr(8'hEC, 8'h0A);
		ask(4'h9, 2'h2, 9'h102);
		wrr(8'hEB, 8'h67);
		wrr(8'hEC, 8'h04);
		ask(4'h9, 2'h2, 9'h082);
		wrr(8'hEB, 8'h07);
		ask(4'h9, 2'h1, 9'h081);
	endtask : t_shared
	task automatic t_buf;
		logic [8:0] a;
		wrr(8'hEA, 8'h00);
		fork
			for (int i = 0; i < 3; i++) host.send(4'h9, 2'(i));
			begin
				repeat (8) @(posedge clk);
				#1;
				chk("ready when full", {8'h00, tr}, 9'h000);
				for (int i = 0; i < 3; i++) begin
					host.take(2, a);
					chk("queued answer", {5'h00, a[8:7], a[1:0]}, 9'h004 + 9'(i));
				end
			end
		join
		chk("drained", {7'h00, av, tr}, 9'h001);
	endtask : t_buf
	task automatic t_wake;
		wrr(8'hEB, 8'h10);
		repeat (2) @(posedge clk);
		#1;
		chk("force K", {8'h00, fk}, 9'h001);
		chk("resume flag", {8'h00, frs}, 9'h000);
		wrr(8'hEB, 8'h00);
		chk("force K", {8'h00, fk}, 9'h000);
		pulse(6'h02);
		chk("resume flag", {8'h00, frs}, 9'h001);
		pulse(6'h20);
		chk("resume flag", {8'h00, frs}, 9'h000);
	endtask : t_wake
	task automatic finish_test;
		if (err_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst, wr, rd, adr, wd, pl, rxc} = {3'h4, 16'h0000, 6'h00, 4'h3};
		repeat (16) @(posedge clk);
		#1;
		rst = 1'b0;
		t_regs;
		t_ep0;
		t_rx;
		t_shared;
		t_buf;
		t_wake;
		finish_test;
	end
	// watchdog well beyond the few hundred cycles the run needs
	initial begin
		#100000;
		err_count++;
		finish_test;
	end
endmodule : tb
